// >>> logic/alu_pkg.sv
package alu_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int IMAGE_W   = 16;
   localparam int WORD_W    = 10;
   localparam int NIB_W     = 4;
   localparam int GPR_IDX_W = 4;
   localparam int PAGE_W    = 2;
   localparam int TIDX_W    = 8;
   localparam int ACC_MSB   = 3;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int IMG_HI_MSB  = 12;
   localparam int IMG_HI_LSB  = 8;
   localparam int IMG_LO_MSB  = 4;
   localparam int IMG_LO_LSB  = 0;
   localparam int TAB_HI_LSB  = 4;
   localparam int TAB_LO_LSB  = 0;
   localparam int IMM_LSB     = 0;
   localparam int CLASS_LSB   = 4;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [NIB_W-1:0]  ACC_RST    = 4'h0;
   localparam logic              CARRY_RST  = 1'h0;
   localparam logic [WORD_W-1:0] TADDR_RST  = 10'h000;

   // the two filler triplets of the image are dropped, never checked
   function automatic logic [WORD_W-1:0] alu_strip_image(input logic [IMAGE_W-1:0] img);
      return {img[IMG_HI_MSB:IMG_HI_LSB], img[IMG_LO_MSB:IMG_LO_LSB]};
   endfunction

   // ------------------------------------------------------------
   // opcodes, as 10-bit core words
   // ------------------------------------------------------------
   localparam logic [WORD_W-1:0] W_AND_R0  = alu_strip_image(16'hFBE0);
   localparam logic [WORD_W-1:0] W_AND_R1  = alu_strip_image(16'hFAE0);
   localparam logic [WORD_W-1:0] W_AND_TH  = alu_strip_image(16'hFAF0);
   localparam logic [WORD_W-1:0] W_AND_TL  = alu_strip_image(16'hFBF0);
   localparam logic [WORD_W-1:0] W_AND_IMM = alu_strip_image(16'hFBF1);
   localparam logic [WORD_W-1:0] W_OR_R0   = alu_strip_image(16'hFDE0);
   localparam logic [WORD_W-1:0] W_OR_R1   = alu_strip_image(16'hFCE0);
   localparam logic [WORD_W-1:0] W_OR_TH   = alu_strip_image(16'hFCF0);
   localparam logic [WORD_W-1:0] W_OR_TL   = alu_strip_image(16'hFDF0);
   localparam logic [WORD_W-1:0] W_OR_IMM  = alu_strip_image(16'hFDF1);
   localparam logic [WORD_W-1:0] W_XOR_R0  = alu_strip_image(16'hF5E0);
   localparam logic [WORD_W-1:0] W_XOR_R1  = alu_strip_image(16'hF4E0);
   localparam logic [WORD_W-1:0] W_XOR_TH  = alu_strip_image(16'hF4F0);
   localparam logic [WORD_W-1:0] W_XOR_TL  = alu_strip_image(16'hF5F0);
   localparam logic [WORD_W-1:0] W_XOR_IMM = alu_strip_image(16'hF5F1);
   localparam logic [WORD_W-1:0] W_INC     = alu_strip_image(16'hF4F3);
   localparam logic [WORD_W-1:0] W_ROT     = alu_strip_image(16'hFCF3);
   localparam logic [WORD_W-1:0] W_ROT_Z   = alu_strip_image(16'hFEF3);

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE, OP_AND, OP_OR, OP_XOR, OP_INC, OP_ROT, OP_ROT_Z
   } alu_op_e;

   typedef enum logic [2:0] {
      SRC_NONE, SRC_GPR, SRC_TAB_HI, SRC_TAB_LO, SRC_IMM
   } alu_src_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_IMM   = 2'h1,
      ST_TABLE = 2'h3
   } alu_state_e;

   typedef struct packed {
      alu_state_e        state;
      alu_op_e           op;
      logic              sel_hi;
      logic [NIB_W-1:0]  acc;
      logic              carry;
      logic              done;
      logic              core_rst;
      logic              table_req;
      logic [WORD_W-1:0] table_addr;
   } alu_core_s;

endpackage

// >>> logic/alu_decode.sv
`timescale 1ns/10ps
`default_nettype none

module alu_decode
   import alu_pkg::*;
(
   // ------------------------------------------------------------
   // core word
   // ------------------------------------------------------------
   input  wire logic [WORD_W-1:0]    word_in,
   // ------------------------------------------------------------
   // decoded fields
   // ------------------------------------------------------------
   output alu_op_e                   op_out,
   output alu_src_e                  src_out,
   output logic                      bank_out,
   output logic [GPR_IDX_W-1:0]      gpr_index_out
);

   assign gpr_index_out = word_in[GPR_IDX_W-1:0];

   always_comb
   begin
      op_out   = OP_NONE;
      src_out  = SRC_NONE;
      bank_out = 1'h0;
      // whole-word forms first
      unique case (word_in)
         W_AND_TH:  begin op_out = OP_AND;   src_out = SRC_TAB_HI; end // [RQ4]
         W_AND_TL:  begin op_out = OP_AND;   src_out = SRC_TAB_LO; end // [RQ4]
         W_AND_IMM: begin op_out = OP_AND;   src_out = SRC_IMM;    end // [RQ6]
         W_OR_TH:   begin op_out = OP_OR;    src_out = SRC_TAB_HI; end // [RQ8]
         W_OR_TL:   begin op_out = OP_OR;    src_out = SRC_TAB_LO; end // [RQ8]
         W_OR_IMM:  begin op_out = OP_OR;    src_out = SRC_IMM;    end // [RQ9]
         W_XOR_TH:  begin op_out = OP_XOR;   src_out = SRC_TAB_HI; end // [RQ11]
         W_XOR_TL:  begin op_out = OP_XOR;   src_out = SRC_TAB_LO; end // [RQ11]
         W_XOR_IMM: begin op_out = OP_XOR;   src_out = SRC_IMM;    end // [RQ12]
         W_INC:     begin op_out = OP_INC;   end // [RQ13]
         W_ROT:     begin op_out = OP_ROT;   end // [RQ14]
         W_ROT_Z:   begin op_out = OP_ROT_Z; end // [RQ15]
         default:
         begin
            // register forms: class in the upper bits, register number in the low nibble
            unique case (word_in[WORD_W-1:CLASS_LSB])
               W_AND_R0[WORD_W-1:CLASS_LSB]: begin op_out = OP_AND; src_out = SRC_GPR; end // [RQ2]
               W_AND_R1[WORD_W-1:CLASS_LSB]:
               begin
                  op_out   = OP_AND; // [RQ2]
                  src_out  = SRC_GPR;
                  bank_out = 1'h1;
               end
               W_OR_R0[WORD_W-1:CLASS_LSB]:  begin op_out = OP_OR; src_out = SRC_GPR; end // [RQ7]
               W_OR_R1[WORD_W-1:CLASS_LSB]:
               begin
                  op_out   = OP_OR; // [RQ7]
                  src_out  = SRC_GPR;
                  bank_out = 1'h1;
               end
               W_XOR_R0[WORD_W-1:CLASS_LSB]: begin op_out = OP_XOR; src_out = SRC_GPR; end // [RQ10]
               W_XOR_R1[WORD_W-1:CLASS_LSB]:
               begin
                  op_out   = OP_XOR; // [RQ10]
                  src_out  = SRC_GPR;
                  bank_out = 1'h1;
               end
               // other words belong to neighbouring units
               default: ;
            endcase
         end
      endcase
   end

endmodule // alu_decode

`default_nettype wire

// >>> logic/alu_unit.sv
// Notes on behaviour
// [RQ1] program words are 10 bits; the two 111 filler triplets of the image are ignored
// [RQ2] and-register ands accumulator with bank0 or bank1 general register n
// [RQ3] and-register carry is accumulator bit 3 and register bit 3
// [RQ4] and-table fetches page/index word, ands high or low nibble
// [RQ5] table and/xor carry is accumulator bit 3 and fetched nibble's top bit
// [RQ6] and-immediate ands second-word nibble; carry is both bit 3s anded
// [RQ7] or-register ors general register into accumulator and clears carry
// [RQ8] or-table ors high or low fetched nibble and clears carry
// [RQ9] or-immediate ors second-word nibble and clears carry
// [RQ10] xor-register xors general register; carry is both bit 3s anded
// [RQ11] xor-table xors high or low nibble of page/index word
// [RQ12] xor-immediate xors second-word nibble; carry is both bit 3s anded
// [RQ13] increment adds one modulo 16, carry set when result is zero
// [RQ14] rotate left moves bit 3 to bit 0 and into carry
// [RQ15] zero-trap rotate raises core reset on zero accumulator, else rotates
// [RQ16] accumulator and operands are 4 bits; each instruction ends in one cycle (immediate forms take two cycles, table forms wait for the fetch)
// [RQ17] increment clears carry when the result is nonzero
`timescale 1ns/10ps
`default_nettype none

module alu_unit
   import alu_pkg::*;
(
   // ------------------------------------------------------------
   // clock and reset
   // ------------------------------------------------------------
   input  wire logic                   clock_in,
   input  wire logic                   sys_rst_in,
   // ------------------------------------------------------------
   // instruction stream
   // ------------------------------------------------------------
   input  wire logic                   instr_valid_in,
   input  wire logic [IMAGE_W-1:0]     instr_image_in,
   output logic                        instr_ready_out,
   // ------------------------------------------------------------
   // general register read
   // ------------------------------------------------------------
   output logic                        gpr_bank_out,
   output logic [GPR_IDX_W-1:0]        gpr_index_out,
   input  wire logic [NIB_W-1:0]       gpr_data_in,
   // ------------------------------------------------------------
   // table fetch from program memory
   // ------------------------------------------------------------
   input  wire logic [PAGE_W-1:0]      table_page_port_in,
   input  wire logic [TIDX_W-1:0]      table_index_reg_in,
   output logic                        table_req_out,
   output logic [WORD_W-1:0]           table_addr_out,
   input  wire logic                   table_valid_in,
   input  wire logic [WORD_W-1:0]      table_word_in,
   // ------------------------------------------------------------
   // accumulator load from neighbouring transfer logic
   // ------------------------------------------------------------
   input  wire logic                   acc_load_in,
   input  wire logic [NIB_W-1:0]       acc_load_data_in,
   // ------------------------------------------------------------
   // results
   // ------------------------------------------------------------
   output logic [NIB_W-1:0]            acc_out,
   output logic                        carry_flag_out,
   output logic                        done_out,
   output logic                        core_reset_out
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   alu_core_s           core_reg;
   alu_core_s           core_next;

   logic [WORD_W-1:0]   word;
   alu_op_e             dec_op;
   alu_src_e            dec_src;
   logic                dec_bank;
   logic [GPR_IDX_W-1:0] dec_index;
   logic [NIB_W-1:0]    imm_nibble;
   logic [NIB_W-1:0]    tab_nibble;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   assign word = alu_strip_image(instr_image_in); // [RQ1]

   alu_decode u_decode
   (
      .word_in       (word),
      .op_out        (dec_op),
      .src_out       (dec_src),
      .bank_out      (dec_bank),
      .gpr_index_out (dec_index)
   );

   assign imm_nibble = word[IMM_LSB +: NIB_W]; // [RQ6]

   // the fetched word is not held; the nibble is chosen as it arrives
   assign tab_nibble = core_reg.sel_hi ? table_word_in[TAB_HI_LSB +: NIB_W]
                                       : table_word_in[TAB_LO_LSB +: NIB_W]; // [RQ4]

   // ------------------------------------------------------------
   // arithmetic: returns {core reset, carry, accumulator}
   // ------------------------------------------------------------
   function automatic logic [NIB_W+1:0] alu_apply
   (
      input alu_op_e          op,
      input logic [NIB_W-1:0] acc,
      input logic             carry,
      input logic [NIB_W-1:0] opnd
   );
      logic [NIB_W-1:0] sum;
      logic             rst;
      logic             cy;
      logic [NIB_W-1:0] res;
      sum = 4'h0;
      rst = 1'h0;
      cy  = carry;
      res = acc;
      unique case (op)
         OP_AND:
         begin
            res = acc & opnd; // [RQ2]
            cy  = acc[ACC_MSB] & opnd[ACC_MSB]; // [RQ3] [RQ5]
         end
         OP_OR:
         begin
            res = acc | opnd; // [RQ7]
            cy  = 1'h0; // [RQ8] [RQ9]
         end
         OP_XOR:
         begin
            res = acc ^ opnd; // [RQ10]
            cy  = acc[ACC_MSB] & opnd[ACC_MSB]; // [RQ10] [RQ5] [RQ12]
         end
         OP_INC:
         begin
            sum = acc + 4'h1; // [RQ13]
            res = sum;
            cy  = (sum == 4'h0); // [RQ13] [RQ17]
         end
         OP_ROT:
         begin
            res = {acc[ACC_MSB-1:0], acc[ACC_MSB]}; // [RQ14]
            cy  = acc[ACC_MSB]; // [RQ14]
         end
         OP_ROT_Z:
         begin
            // a zero accumulator traps; accumulator and carry keep their values
            if (acc == 4'h0)
            begin
               rst = 1'h1; // [RQ15]
            end
            else
            begin
               res = {acc[ACC_MSB-1:0], acc[ACC_MSB]}; // [RQ15]
               cy  = acc[ACC_MSB];
            end
         end
         default: ;
      endcase
      return {rst, cy, res};
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic [NIB_W+1:0] result;
      result         = {1'h0, core_reg.carry, core_reg.acc};
      core_next      = core_reg;
      core_next.done     = 1'h0;
      core_next.core_rst = 1'h0;
      unique case (core_reg.state)
         ST_IDLE:
         begin
            if (instr_valid_in && (dec_op != OP_NONE))
            begin
               unique case (dec_src)
                  SRC_GPR, SRC_NONE:
                  begin
                     // single-word forms finish in the cycle they are taken
                     result = alu_apply(dec_op, core_reg.acc, core_reg.carry,
                                        gpr_data_in); // [RQ16]
                     core_next.acc      = result[NIB_W-1:0];
                     core_next.carry    = result[NIB_W];
                     core_next.core_rst = result[NIB_W+1];
                     core_next.done     = 1'h1;
                  end
                  SRC_IMM:
                  begin
                     core_next.op    = dec_op;
                     core_next.state = ST_IMM;
                  end
                  SRC_TAB_HI, SRC_TAB_LO:
                  begin
                     core_next.op         = dec_op;
                     core_next.sel_hi     = (dec_src == SRC_TAB_HI);
                     core_next.table_req  = 1'h1; // [RQ4] [RQ11]
                     core_next.table_addr = {table_page_port_in, table_index_reg_in};
                     core_next.state      = ST_TABLE;
                  end
                  default: ;
               endcase
            end
            else if (acc_load_in)
            begin
               core_next.acc = acc_load_data_in;
            end
         end
         ST_IMM:
         begin
            // second word carries the nibble in its low bits
            if (instr_valid_in)
            begin
               result = alu_apply(core_reg.op, core_reg.acc, core_reg.carry,
                                  imm_nibble); // [RQ6] [RQ9] [RQ12]
               core_next.acc   = result[NIB_W-1:0];
               core_next.carry = result[NIB_W];
               core_next.done  = 1'h1;
               core_next.state = ST_IDLE;
            end
         end
         ST_TABLE:
         begin
            // no new words are taken while the fetch is outstanding
            if (table_valid_in)
            begin
               result = alu_apply(core_reg.op, core_reg.acc, core_reg.carry,
                                  tab_nibble); // [RQ4] [RQ8] [RQ11]
               core_next.acc       = result[NIB_W-1:0];
               core_next.carry     = result[NIB_W];
               core_next.table_req = 1'h0;
               core_next.done      = 1'h1;
               core_next.state     = ST_IDLE;
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         core_reg.state      <= ST_IDLE;
         core_reg.op         <= OP_NONE;
         core_reg.sel_hi     <= 1'h0;
         core_reg.acc        <= ACC_RST;
         core_reg.carry      <= CARRY_RST;
         core_reg.done       <= 1'h0;
         core_reg.core_rst   <= 1'h0;
         core_reg.table_req  <= 1'h0;
         core_reg.table_addr <= TADDR_RST;
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign instr_ready_out = (core_reg.state != ST_TABLE);
   assign gpr_bank_out    = dec_bank; // [RQ2]
   assign gpr_index_out   = dec_index;
   assign table_req_out   = core_reg.table_req;
   assign table_addr_out  = core_reg.table_addr;
   assign acc_out         = core_reg.acc;
   assign carry_flag_out  = core_reg.carry;
   assign done_out        = core_reg.done;
   assign core_reset_out  = core_reg.core_rst; // [RQ15]

endmodule // alu_unit

`default_nettype wire

// >>> bench/alu_unit_chk.sv
`timescale 1ns/10ps
`default_nettype none

module alu_unit_chk
   import alu_pkg::*;
(
   // clock, reset and stream
   input wire logic               clock_in,
   input wire logic               sys_rst_in,
   input wire logic               instr_valid_in,
   input wire logic [IMAGE_W-1:0] instr_image_in,
   input wire logic               instr_ready_out,
   input wire logic               gpr_bank_out,
   input wire logic [NIB_W-1:0]   gpr_data_in,
   // table fetch
   input wire logic [PAGE_W-1:0]  table_page_port_in,
   input wire logic [TIDX_W-1:0]  table_index_reg_in,
   input wire logic               table_req_out,
   input wire logic [WORD_W-1:0]  table_addr_out,
   input wire logic               table_valid_in,
   input wire logic [WORD_W-1:0]  table_word_in,
   // results
   input wire logic [NIB_W-1:0]   acc_out,
   input wire logic               carry_flag_out,
   input wire logic               done_out,
   input wire logic               core_reset_out
);
   // ------------------------------------------------------------
   // helper state: which operation is pending
   // ------------------------------------------------------------
   logic [WORD_W-1:0] w;
   logic              imm_wait_reg;
   logic [1:0]        kind_reg;
   logic              hi_reg;
   logic              take, is_alu;
   assign w      = {instr_image_in[12:8], instr_image_in[4:0]};
   assign take   = instr_valid_in && instr_ready_out && !imm_wait_reg;
   assign is_alu = w[9:6] == W_AND_R0[9:6] || w[9:6] == W_OR_R0[9:6] || w[9:6] == W_XOR_R0[9:6];

   function automatic logic [4:0] f_res(logic [1:0] k, logic [3:0] a, logic [3:0] o);
      case (k)
         2'h0:    return {a[3] & o[3], a & o};
         2'h1:    return {1'b0, a | o};
         default: return {a[3] & o[3], a ^ o};
      endcase
   endfunction

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         imm_wait_reg <= 1'b0;
      else if (imm_wait_reg && instr_valid_in)
         imm_wait_reg <= 1'b0;
      else if (take && (w == W_AND_IMM || w == W_OR_IMM || w == W_XOR_IMM))
         imm_wait_reg <= 1'b1;
      if (take)
      begin
         kind_reg <= (w[9:6] == W_AND_R0[9:6]) ? 2'h0 : (w[9:6] == W_OR_R0[9:6]) ? 2'h1 : 2'h2;
         hi_reg   <= !w[5];
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_reg_take;
      take && is_alu && !w[4];
   endsequence
   sequence s_tab_take;
      take && is_alu && w[4:0] == 5'h10;
   endsequence

   a_reg_ops: assert property (s_reg_take |=> done_out &&
      {carry_flag_out, acc_out} == f_res(kind_reg, $past(acc_out), $past(gpr_data_in)))
      else $error("register form result wrong");
   a_gpr_bank: assert property (s_reg_take |-> gpr_bank_out == !w[5])
      else $error("register bank select wrong");
   a_imm_ops: assert property (imm_wait_reg && instr_valid_in |=> done_out &&
      {carry_flag_out, acc_out} == f_res(kind_reg, $past(acc_out), $past(instr_image_in[3:0])))
      else $error("immediate form result wrong");
   a_table_req: assert property (s_tab_take |=> table_req_out && !instr_ready_out &&
      table_addr_out == $past({table_page_port_in, table_index_reg_in}))
      else $error("table fetch request wrong");
   a_table_ops: assert property (table_req_out && table_valid_in |=> done_out &&
      !table_req_out && {carry_flag_out, acc_out} == f_res(kind_reg, $past(acc_out),
      hi_reg ? $past(table_word_in[7:4]) : $past(table_word_in[3:0])))
      else $error("table form result wrong");
   a_inc_wrap: assert property (take && w == W_INC |=> done_out &&
      acc_out == $past(acc_out) + 4'h1 && carry_flag_out == (acc_out == 4'h0))
      else $error("increment result wrong");
   a_rotate_left: assert property (take && (w == W_ROT || (w == W_ROT_Z && acc_out != 4'h0))
      |=> done_out && !core_reset_out && carry_flag_out == $past(acc_out[3]) &&
      acc_out == {$past(acc_out[2:0]), $past(acc_out[3])})
      else $error("rotate result wrong");
   a_zero_trap: assert property (take && w == W_ROT_Z && acc_out == 4'h0 |=>
      core_reset_out && $stable(acc_out) && $stable(carry_flag_out))
      else $error("zero trap missing");
   a_no_done: assert property (!(instr_valid_in && instr_ready_out) &&
      !(table_req_out && table_valid_in) |=> !done_out)
      else $error("done without completion");
   a_reset_vals: assert property ($fell(sys_rst_in) |-> acc_out == 4'h0 &&
      !carry_flag_out && !done_out && !core_reset_out && !table_req_out && instr_ready_out)
      else $error("reset values wrong");

endmodule // alu_unit_chk

bind alu_unit alu_unit_chk u_alu_unit_chk (.*);

`default_nettype wire

// >>> bench/tb_accumulator_logic_unit.sv
`timescale 1ns/10ps
`default_nettype none

module tb_accumulator_logic_unit;
   import alu_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clock_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        instr_valid_in = 1'b0;
   logic        table_valid_in = 1'b0;
   logic        acc_load_in = 1'b0;
   logic [15:0] instr_image_in = 16'h0000;
   logic [3:0]  gpr_data_in = 4'h0;
   logic [3:0]  acc_load_data_in = 4'h0;
   logic [1:0]  table_page_port_in = 2'h0;
   logic [7:0]  table_index_reg_in = 8'h00;
   logic [9:0]  table_word_in = 10'h000;
   logic        instr_ready_out, gpr_bank_out, table_req_out;
   logic        carry_flag_out, done_out, core_reset_out;
   logic [3:0]  gpr_index_out, acc_out;
   logic [9:0]  table_addr_out;
   int          error_cnt = 0;
   int          n_compared = 0;
   logic [31:0] seed = 32'hB86E;
   logic [3:0]  m_acc = 4'h0;
   logic        m_cy = 1'b0;
   localparam logic [15:0] OPS [18] = '{16'hFBE0, 16'hFAE0, 16'hFAF0, 16'hFBF0, 16'hFBF1,
      16'hFDE0, 16'hFCE0, 16'hFCF0, 16'hFDF0, 16'hFDF1, 16'hF5E0, 16'hF4E0, 16'hF4F0,
      16'hF5F0, 16'hF5F1, 16'hF4F3, 16'hFCF3, 16'hFEF3};

   always #5 clock_in = ~clock_in;

   alu_unit u_alu_unit (.*);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
      return seed;
   endfunction

   // returns {trap, carry, acc}
   function automatic logic [5:0] exp_step(logic [15:0] img, logic [3:0] a, logic c,
      logic [3:0] g, logic [3:0] im, logic [9:0] tw);
      logic [3:0] o, r;
      logic       n, t;
      t = 1'b0;
      r = a;
      n = c;
      o = (img[7:0] == 8'hF1) ? im : (img[7:0] == 8'hF0) ? (img[8] ? tw[3:0] : tw[7:4]) : g;
      if (img[7:0] == 8'hF3)
      begin
         if (img[15:8] == 8'hF4)
         begin
            r = a + 4'h1;
            n = (r == 4'h0);
         end
         else if (img[15:8] == 8'hFE && a == 4'h0)
            t = 1'b1;
         else
         begin
            r = {a[2:0], a[3]};
            n = a[3];
         end
      end
      else if (img[15:9] == 7'h7D)
         {n, r} = {a[3] & o[3], a & o};
      else if (img[15:9] == 7'h7E)
         {n, r} = {1'b0, a | o};
      else
         {n, r} = {a[3] & o[3], a ^ o};
      return {t, n, r};
   endfunction

   task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
      n_compared++;
      if (e !== g)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic step();
      @(posedge clock_in);
      #1;
   endtask

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one instruction; a refused word stands on the stream while a fetch waits
   task automatic run(logic [15:0] img, logic [3:0] im, logic [9:0] tw, int dly);
      logic [31:0] r;
      logic [31:0] q;
      logic [5:0]  e;
      r = rnd();
      instr_valid_in = 1'b1;
      instr_image_in = img;
      gpr_data_in = r[3:0];
      table_page_port_in = r[5:4];
      table_index_reg_in = r[13:6];
      e = exp_step(img, m_acc, m_cy, r[3:0], im, tw);
      step();
      if (img[7:4] == 4'hE)
      begin
         chk("gpr_index", {6'h0, img[3:0]}, gpr_index_out);
         chk("gpr_bank", {9'h0, ~img[8]}, gpr_bank_out);
      end
      if (img[7:0] == 8'hF1)
      begin
         instr_image_in = {r[27:16], im};
         step();
      end
      else if (img[7:0] == 8'hF0)
      begin
         instr_image_in = ~img;
         chk("table_req", 10'h1, table_req_out);
         chk("table_addr", {r[5:4], r[13:6]}, table_addr_out);
         chk("ready", 10'h0, instr_ready_out);
         repeat (dly)
         begin
            q = rnd();
            table_word_in = q[9:0];
            step();
         end
         table_valid_in = 1'b1;
         table_word_in = tw;
         step();
         table_valid_in = 1'b0;
         table_word_in = ~tw;
      end
      if (!e[5])
         chk("done", 10'h1, done_out);
      chk("trap", e[5], core_reset_out);
      chk("acc", e[3:0], acc_out);
      chk("carry", e[4], carry_flag_out);
      m_acc = e[3:0];
      m_cy = e[4];
   endtask

   task automatic rand_run(logic [15:0] img);
      logic [31:0] r;
      r = rnd();
      if (img[7:4] == 4'hE)
         img[3:0] = r[3:0];
      run(img, r[7:4], r[17:8], int'(r[19:18]));
   endtask

   task automatic load(logic [3:0] v);
      instr_valid_in = 1'b0;
      acc_load_in = 1'b1;
      acc_load_data_in = v;
      step();
      acc_load_in = 1'b0;
      chk("load", v, acc_out);
      chk("load_done", 10'h0, done_out);
      m_acc = v;
   endtask

   task automatic do_reset();
      instr_valid_in = 1'b0;
      sys_rst_in = 1'b1;
      repeat (5) step();
      sys_rst_in = 1'b0;
      chk("rst_acc", 10'h0, acc_out);
      chk("rst_carry", 10'h0, carry_flag_out);
      chk("rst_req", 10'h0, table_req_out);
      chk("rst_ready", 10'h1, instr_ready_out);
      m_acc = 4'h0;
      m_cy = 1'b0;
   endtask

   // ------------------------------------------------------------
   // sequence: every opcode, corners, then random traffic
   // ------------------------------------------------------------
   initial
   begin
      logic [31:0] r;
      do_reset();
      foreach (OPS[i])
         rand_run(OPS[i]);
      load(4'hF);
      rand_run(16'hF4F3);
      rand_run(16'hF4F3);
      load(4'h0);
      rand_run(16'hFEF3);
      instr_image_in = 16'hFFE3;
      step();
      chk("other_done", 10'h0, done_out);
      do_reset();
      load(4'h8);
      rand_run(16'hFCF3);
      rand_run(16'hFEF3);
      repeat (400)
      begin
         r = rnd();
         rand_run(OPS[r[12:8] % 18]);
      end
      give_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge clock_in);
      error_cnt++;
      give_verdict();
   end

endmodule // tb_accumulator_logic_unit

`default_nettype wire
